/* File: hw/eil_top.sv */
// External interrupt latch: pin edge/level capture, acknowledge, mask and registers
module eil_top
    import eil_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ext_int_pin_n,
    input wire logic vector_fetch_ack,
    input wire logic [EIL_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic cpu_int_request,
    output logic pin_level_high,
    output logic irq_out
);

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    eil_sync_if sync_bus ();

    eil_pin_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_n(ext_int_pin_n),
        .sync(sync_bus.producer)
    );

    logic ext_int_request_latch_reg;
    logic ext_int_request_latch_next;
    logic ack_pending_reg;
    logic ack_pending_next;
    logic ext_int_mask_bit_reg;
    logic trigger_select_bit_reg;
    logic [EIL_EV_W-1:0] ev_status_reg;
    logic [EIL_EV_W-1:0] ev_status_next;
    logic [EIL_EV_W-1:0] ev_mask_reg;
    logic [7:0] reg_rdata_reg;
    logic [7:0] rdata_next;
    logic cpu_int_request_reg;
    logic pin_level_reg;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    wire sel_ctrl = (reg_addr == EIL_STATUS_CTRL_OFS);
    wire sel_ev_stat = (reg_addr == EIL_IRQ_STATUS_OFS);
    wire sel_ev_mask = (reg_addr == EIL_IRQ_MASK_OFS);
    wire wr_ctrl = reg_wr && sel_ctrl;
    wire sw_ack = wr_ctrl && reg_wdata[EIL_ACK_BIT_POS];
    wire any_ack = sw_ack || vector_fetch_ack;
    wire pin_low = !sync_bus.pin_level;
    wire fall = sync_bus.fall_pulse;

    // Level mode sets on low level as well as edge; edge detect never gated by ack
    wire set_req = fall || (trigger_select_bit_reg && pin_low);

    // ****************************************************************
    // Latch next-state
    // ****************************************************************
    // Edge mode: ack clears at once. Level mode: ack is remembered until pin is high,
    // so acknowledge and pin release may come in either order.
    always_comb begin
        ack_pending_next = ack_pending_reg;
        ext_int_request_latch_next = ext_int_request_latch_reg;
        if (!trigger_select_bit_reg) begin
            ack_pending_next = 1'b0;
            if (any_ack) begin
                ext_int_request_latch_next = 1'b0;
            end
        end else begin
            if (any_ack) begin
                ack_pending_next = 1'b1;
            end
            if ((any_ack || ack_pending_reg) && !pin_low) begin
                ext_int_request_latch_next = 1'b0;
                ack_pending_next = 1'b0;
            end
        end
        // New event wins over a clear in the same cycle
        if (set_req) begin
            ext_int_request_latch_next = 1'b1;
        end
    end

    // ****************************************************************
    // Interrupt status: latch rise and software ack; write one clears
    // ****************************************************************
    wire [EIL_EV_W-1:0] ev_set = {sw_ack, set_req && !ext_int_request_latch_reg};
    wire [EIL_EV_W-1:0] ev_clr = (reg_wr && sel_ev_stat) ? reg_wdata[EIL_EV_W-1:0] : '0;

    // Set beats clear per bit
    always_comb begin
        ev_status_next = ev_status_reg;
        for (int i = 0; i < EIL_EV_W; i++) begin
            ev_status_next[i] = ev_set[i] || (ev_status_reg[i] && !ev_clr[i]);
        end
    end

    // ****************************************************************
    // Read mux; acknowledge always reads zero
    // ****************************************************************
    wire [7:0] ctrl_rd = {3'h0,
        sync_bus.pin_level,
        ext_int_request_latch_reg,
        1'b0,
        ext_int_mask_bit_reg,
        trigger_select_bit_reg};
    assign rdata_next = !reg_rd ? 8'h00 :
        sel_ctrl ? ctrl_rd :
        sel_ev_stat ? {6'h00, ev_status_reg} :
        sel_ev_mask ? {6'h00, ev_mask_reg} : 8'h00;

    // ****************************************************************
    // State registers; reset clears latch and all control bits
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_int_request_latch_reg <= 1'b0;
            ack_pending_reg <= 1'b0;
            ext_int_mask_bit_reg <= EIL_STATUS_CTRL_RST[EIL_MASK_BIT_POS];
            trigger_select_bit_reg <= EIL_STATUS_CTRL_RST[EIL_TRIG_BIT_POS];
            ev_status_reg <= EIL_EV_RST;
            ev_mask_reg <= EIL_EV_RST;
            reg_rdata_reg <= 8'h00;
            cpu_int_request_reg <= 1'b0;
            pin_level_reg <= 1'b1;
        end else begin
            ext_int_request_latch_reg <= ext_int_request_latch_next;
            ack_pending_reg <= ack_pending_next;
            ev_status_reg <= ev_status_next;
            reg_rdata_reg <= rdata_next;
            pin_level_reg <= sync_bus.pin_level;
            cpu_int_request_reg <= ext_int_request_latch_next && !ext_int_mask_bit_reg;
            if (wr_ctrl) begin
                ext_int_mask_bit_reg <= reg_wdata[EIL_MASK_BIT_POS];
                trigger_select_bit_reg <= reg_wdata[EIL_TRIG_BIT_POS];
            end
            if (reg_wr && sel_ev_mask) begin
                ev_mask_reg <= reg_wdata[EIL_EV_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Outputs, all registered except irq_out, which is decoded from status and mask registers
    // ****************************************************************
    assign reg_rdata = reg_rdata_reg;
    assign cpu_int_request = cpu_int_request_reg;
    assign pin_level_high = pin_level_reg;
    assign irq_out = |(ev_status_reg & ev_mask_reg);

endmodule

/* File: hw/eil_pkg.sv */
// Package of register offsets, bit positions and reset values for the external interrupt latch
package eil_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int EIL_ADDR_W = 4;
    localparam logic [EIL_ADDR_W-1:0] EIL_STATUS_CTRL_OFS = 4'h0;
    localparam logic [EIL_ADDR_W-1:0] EIL_IRQ_STATUS_OFS = 4'h4;
    localparam logic [EIL_ADDR_W-1:0] EIL_IRQ_MASK_OFS = 4'h8;

    // ****************************************************************
    // Status and control field positions
    // ****************************************************************
    localparam int EIL_MASK_BIT_POS = 1;
    localparam int EIL_ACK_BIT_POS = 2;
    localparam int EIL_FLAG_BIT_POS = 3;
    localparam int EIL_PIN_LVL_POS = 4;
    localparam int EIL_TRIG_BIT_POS = 0;

    // ****************************************************************
    // Interrupt status bits and reset values
    // ****************************************************************
    localparam int EIL_EV_LATCH_POS = 0;
    localparam int EIL_EV_SWACK_POS = 1;
    localparam int EIL_EV_W = 2;
    localparam logic [7:0] EIL_STATUS_CTRL_RST = 8'h00;
    localparam logic [EIL_EV_W-1:0] EIL_EV_RST = 2'h0;

    // Edge detector states
    typedef enum logic [1:0] {
        EIL_LVL_HIGH = 2'b01,
        EIL_LVL_LOW = 2'b10
    } eil_lvl_type;

endpackage

/* File: hw/eil_sync_if.sv */
// Interface carrying the synchronised pin level and its falling-edge pulse
interface eil_sync_if;
    logic pin_level;
    logic fall_pulse;
    modport producer (output pin_level, output fall_pulse);
    modport consumer (input pin_level, input fall_pulse);
endinterface

/* File: hw/eil_pin_sync.sv */
// Two-flop synchroniser and falling-edge detector for the interrupt pin
module eil_pin_sync
    import eil_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pin_n,
    eil_sync_if.producer sync
);

    logic meta_reg;
    logic level_reg;
    eil_lvl_type state_reg;
    eil_lvl_type state_next;

    // ****************************************************************
    // Synchroniser; idle pin is high so reset to one
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= 1'b1;
            level_reg <= 1'b1;
            state_reg <= EIL_LVL_HIGH;
        end else begin
            meta_reg <= pin_n;
            level_reg <= meta_reg;
            state_reg <= state_next;
        end
    end

    // Edge seen as high-to-low between synchronised samples
    always_comb begin
        case (state_reg)
            EIL_LVL_HIGH: state_next = level_reg ? EIL_LVL_HIGH : EIL_LVL_LOW;
            EIL_LVL_LOW: state_next = level_reg ? EIL_LVL_HIGH : EIL_LVL_LOW;
            default: state_next = EIL_LVL_HIGH;
        endcase
    end

    assign sync.pin_level = level_reg;
    assign sync.fall_pulse = (state_reg == EIL_LVL_HIGH) && !level_reg;

endmodule

/* File: tb/eil_cpu_model.sv */
// CPU side: global mask check and vector fetch acknowledge
module eil_cpu_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic int_req,
    input wire logic global_mask,
    input wire logic [2:0] lat,
    output logic vector_fetch_ack
);
    logic [2:0] wait_c;
    logic [15:0] pc_vec;
    // Serve after lat cycles; global mask blocks all
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_c <= 3'h0;
            vector_fetch_ack <= 1'b0;
            pc_vec <= 16'h0000;
        end else if (vector_fetch_ack) begin
            vector_fetch_ack <= 1'b0;
            wait_c <= 3'h0;
        end else if (int_req && !global_mask) begin
            if (wait_c >= lat) begin
                vector_fetch_ack <= 1'b1;
                pc_vec <= 16'hfffa;
            end
            wait_c <= wait_c + 3'h1;
        end else begin
            wait_c <= 3'h0;
        end
    end
endmodule

/* File: tb/eil_assertions.sv */
// Port checker of the external interrupt latch
module eil_chk
    import eil_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ext_int_pin_n,
    input wire logic vector_fetch_ack,
    input wire logic [EIL_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic cpu_int_request,
    input wire logic pin_level_high,
    input wire logic irq_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic mode_h;
    logic mask_h;
    logic [2:0] hi_c;
    logic [2:0] lo_c;
    wire ctl_wr = reg_wr && reg_addr == EIL_STATUS_CTRL_OFS;
    wire ctl_rd = reg_rd && reg_addr == EIL_STATUS_CTRL_OFS;
    wire quiet = hi_c > 3'h2 || lo_c > 3'h2;
    // Mirror of mode and mask; pin run lengths rule out a fresh fall
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_h <= 1'b0;
            mask_h <= 1'b0;
            hi_c <= 3'h0;
            lo_c <= 3'h0;
        end else begin
            if (ctl_wr) mode_h <= reg_wdata[EIL_TRIG_BIT_POS];
            if (ctl_wr) mask_h <= reg_wdata[EIL_MASK_BIT_POS];
            hi_c <= !ext_int_pin_n ? 3'h0 : (&hi_c ? hi_c : hi_c + 3'h1);
            lo_c <= ext_int_pin_n ? 3'h0 : (&lo_c ? lo_c : lo_c + 3'h1);
        end
    end
    AST_ACK_RD: assert property (ctl_rd |=> !reg_rdata[EIL_ACK_BIT_POS])
        else $error("ack bit reads one");
    AST_PIN_HI: assert property (ext_int_pin_n [*4] |-> pin_level_high)
        else $error("pin level not high");
    AST_PIN_LO: assert property (!ext_int_pin_n [*4] |-> !pin_level_high)
        else $error("pin level not low");
    AST_CTRL_RD: assert property (ctl_rd |=> reg_rdata[1:0] == {mask_h, mode_h})
        else $error("mask or mode readback wrong");
    AST_VF_CLR: assert property (vector_fetch_ack && !mode_h && quiet |=> !cpu_int_request)
        else $error("fetch ack left request");
    AST_SW_CLR: assert property (ctl_wr && reg_wdata[2:0] == 3'h4 && !mode_h && quiet
        |=> !cpu_int_request) else $error("soft ack left request");
    AST_LVL_HOLD: assert property (mode_h && $past(mode_h) && !mask_h && !$past(mask_h)
        && lo_c > 3'h3 |-> cpu_int_request) else $error("low pin lost request");
    AST_MASK_BLK: assert property (mask_h && $past(mask_h) |-> !cpu_int_request)
        else $error("masked request forwarded");
    C_VF: cover property (vector_fetch_ack && mode_h);
    C_SW: cover property (ctl_wr && reg_wdata[EIL_ACK_BIT_POS]);
    C_IRQ: cover property ($rose(irq_out));
endmodule
bind eil_top eil_chk u_chk (.*);

/* File: tb/external_interrupt_latch_tb.sv */
// Self-checking bench of the external interrupt latch
module external_interrupt_latch_tb
    import eil_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, reset_n = 0, pin_n = 1, vfa, gmask = 1, rd_d = 0, wr = 0, rd = 0;
    logic req, lvl, irq;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00, rdata, t;
    logic [2:0] lat = 3'h1;
    logic [7:0] exp_q[$];
    int fail_count = 0, n_tests = 0, n_ack = 0, cyc = 0, seed = 32'h0f383a0b;
    eil_top DUT (.clk(clk), .reset_n(reset_n), .ext_int_pin_n(pin_n),
        .vector_fetch_ack(vfa), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .cpu_int_request(req),
        .pin_level_high(lvl), .irq_out(irq));
    eil_cpu_model cpu (.clk(clk), .reset_n(reset_n), .int_req(req),
        .global_mask(gmask), .lat(lat), .vector_fetch_ack(vfa));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task wr_r(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task rd_r(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 0;
    endtask
    // Settle past the two-flop pin path, then check request and irq
    task lv(input logic r, input logic i);
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk({6'h0, req, irq}, {6'h0, r, i});
        // Back onto a rising edge so the next stimulus lands there
        @(posedge clk);
    endtask
    // Read data stand one cycle only, so compare at that cycle's middle
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) if (rd_d) chk(rdata, exp_q.pop_front());
    always @(posedge clk) begin
        if (vfa) n_ack++;
        cyc++;
        if (cyc > 2000) begin
            fail_count++;
            results;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1;
        rd_r(EIL_STATUS_CTRL_OFS, 8'h10);
        rd_r(EIL_IRQ_STATUS_OFS, 8'h00);
        t = 8'($random(seed));
        wr_r(EIL_IRQ_MASK_OFS, t);
        wr_r(4'hc, t);
        rd_r(EIL_IRQ_MASK_OFS, {6'h0, t[1:0]});
        rd_r(4'hc, 8'h00);
        wr_r(EIL_IRQ_MASK_OFS, 8'h03);
        pin_n <= 0;
        lv(1, 1);
        rd_r(EIL_STATUS_CTRL_OFS, 8'h08);
        wr_r(EIL_STATUS_CTRL_OFS, 8'h04);
        lv(0, 1);
        rd_r(EIL_STATUS_CTRL_OFS, 8'h00);
        rd_r(EIL_IRQ_STATUS_OFS, 8'h03);
        wr_r(EIL_IRQ_STATUS_OFS, 8'h03);
        lv(0, 0);
        // A new fall after the software acknowledge latches again
        pin_n <= 1;
        lv(0, 0);
        pin_n <= 0;
        lv(1, 1);
        wr_r(EIL_STATUS_CTRL_OFS, 8'h02);
        lv(0, 1);
        rd_r(EIL_STATUS_CTRL_OFS, 8'h0a);
        wr_r(EIL_STATUS_CTRL_OFS, 8'h00);
        lv(1, 1);
        wr_r(EIL_IRQ_STATUS_OFS, 8'h01);
        lat <= 3'($random(seed)) | 3'h1;
        gmask <= 0;
        for (int k = 0; k < 20 && n_ack == 0; k++) @(posedge clk);
        lv(0, 0);
        chk(8'(n_ack), 8'h01);
        // Level mode: acknowledges cannot clear while the pin is low
        gmask <= 1;
        pin_n <= 1;
        lv(0, 0);
        wr_r(EIL_STATUS_CTRL_OFS, 8'h01);
        pin_n <= 0;
        gmask <= 0;
        lv(1, 1);
        gmask <= 1;
        wr_r(EIL_STATUS_CTRL_OFS, 8'h05);
        lv(1, 1);
        rd_r(EIL_STATUS_CTRL_OFS, 8'h09);
        // Handler masks the request while the level trigger is in use
        wr_r(EIL_STATUS_CTRL_OFS, 8'h03);
        pin_n <= 1;
        lv(0, 1);
        rd_r(EIL_STATUS_CTRL_OFS, 8'h13);
        wr_r(EIL_STATUS_CTRL_OFS, 8'h01);
        pin_n <= 0;
        lv(1, 1);
        reset_n <= 0;
        pin_n <= 1;
        repeat (2) @(posedge clk);
        reset_n <= 1;
        lv(0, 0);
        rd_r(EIL_STATUS_CTRL_OFS, 8'h10);
        rd_r(EIL_IRQ_MASK_OFS, 8'h00);
        results;
    end
endmodule
